// [alt_space_load_atomic_unit.v]
// alternate-space integer load, quad atomic load and load-store byte unit
//
`timescale 1ns/1ps
`include "alt_load_consts.vh"

module alt_space_load_atomic_unit (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire ISSUE_I,
  input wire [31:0] INSTR_I,
  input wire [63:0] SRC1_I,
  input wire [63:0] SRC2_I,
  input wire [7:0] ASI_REG_I,
  input wire PRIV_STATE_I,
  output wire BUSY_O,
  output reg MEM_REQ_O,
  output reg MEM_WRITE_O,
  output reg MEM_LOCK_O,
  output reg [63:0] MEM_ADDR_O,
  output reg [7:0] MEM_ASI_O,
  output reg [1:0] MEM_SIZE_O,
  output reg MEM_LITTLE_O,
  output reg MEM_BYPASS_O,
  output reg MEM_NUCLEUS_O,
  output reg [7:0] MEM_ATTR_O,
  output reg MEM_ATTR_FIXED_O,
  output reg MEM_WATCH_EN_O,
  output reg [7:0] MEM_WDATA_O,
  input wire MEM_ACK_I,
  input wire [63:0] MEM_RDATA_I,
  input wire MEM_CACHEABLE_I,
  input wire MEM_FAULT_I,
  input wire WATCH_HIT_I,
  output reg DONE_O,
  output reg WB_EN_O,
  output reg [4:0] WB_REG_O,
  output reg [63:0] WB_DATA_O,
  output reg TRAP_O,
  output reg TRAP_PRIV_O,
  output reg TRAP_ALIGN_O,
  output reg TRAP_ILLEGAL_O,
  output reg TRAP_ACCESS_O,
  output reg TRAP_WATCH_O
);

  // instruction fields
  wire [4:0] rd_f = INSTR_I[`F_RD_HI:`F_RD_LO];
  wire [5:0] op_f = INSTR_I[`F_OP_HI:`F_OP_LO];
  wire i_f = INSTR_I[`F_IBIT];
  wire [7:0] imm_asi_f = INSTR_I[`F_ASI_HI:`F_ASI_LO];
  wire [12:0] offset_f = INSTR_I[12:0];

  // decode
  wire is_ld = (op_f == `OP_LDSBA) || (op_f == `OP_LDSHA) || (op_f == `OP_LDSWA) ||
    (op_f == `OP_LDUBA) || (op_f == `OP_LDUHA) || (op_f == `OP_LDUWA) || (op_f == `OP_LDXA);
  wire is_ldda = (op_f == `OP_LDDA);
  wire is_lsub = (op_f == `OP_LSUB);
  wire is_lsuba = (op_f == `OP_LSUBA);
  // alternate-space forms carry their own space identifier
  wire alt = is_ld || is_ldda || is_lsuba;
  wire known = alt || is_lsub;

  // space selection and effective address
  wire [7:0] asi = !alt ? `ASI_PRIMARY : (i_f ? ASI_REG_I : imm_asi_f);
  wire [63:0] ea = i_f ? SRC1_I + {{51{offset_f[12]}}, offset_f} : SRC1_I + SRC2_I;

  // quad space classes: translated or physical
  wire q_virt = (asi == `ASI_QV) || (asi == `ASI_QV_L);
  wire q_phys = (asi == `ASI_QP) || (asi == `ASI_QP_L);
  wire q_space = q_virt || q_phys;
  wire quad = is_ldda && q_space;

  // access size and sign
  reg [1:0] size;
  reg signed_ld;
  always @* begin
    size = `SZ_BYTE;
    signed_ld = 1'b0;
    case (op_f)
      `OP_LDSBA: signed_ld = 1'b1;
      `OP_LDSHA: begin
        size = `SZ_HALF;
        signed_ld = 1'b1;
      end
      `OP_LDSWA: begin
        size = `SZ_WORD;
        signed_ld = 1'b1;
      end
      `OP_LDUHA: size = `SZ_HALF;
      `OP_LDUWA: size = `SZ_WORD;
      `OP_LDXA: size = `SZ_DWORD;
      `OP_LDDA: size = `SZ_DWORD;
      default: size = `SZ_BYTE;
    endcase
  end

  // issue-time checks, highest priority first
  wire illegal = !known || (is_ldda && !q_space) || (quad && rd_f[0]);
  wire priv_viol = alt && !asi[`ASI_PRIV_BIT] && !PRIV_STATE_I;
  wire misuse = alt && !is_ldda && q_space;
  reg misal;
  always @* begin
    misal = 1'b0;
    if (quad) begin
      misal = |(ea & `QUAD_ALIGN_MASK);
    end else begin
      case (size)
        `SZ_HALF: misal = ea[0];
        `SZ_WORD: misal = |ea[1:0];
        `SZ_DWORD: misal = |ea[2:0];
        default: misal = 1'b0;
      endcase
    end
  end

  // held operation state
  reg [2:0] state_q;
  reg quad_q;
  reg lsub_q;
  reg signed_q;
  reg [1:0] size_q;
  reg [4:0] rd_q;
  reg [63:0] lo_q;
  reg [2:0] lane_q;

  // busy while any beat or write-back is pending
  assign BUSY_O = (state_q != `ST_IDLE);

  // extension of the fetched value
  reg [63:0] ext;
  always @* begin
    ext = MEM_RDATA_I;
    case (size_q)
      `SZ_BYTE: ext = {{56{signed_q & MEM_RDATA_I[7]}}, MEM_RDATA_I[7:0]};
      `SZ_HALF: ext = {{48{signed_q & MEM_RDATA_I[15]}}, MEM_RDATA_I[15:0]};
      `SZ_WORD: ext = {{32{signed_q & MEM_RDATA_I[31]}}, MEM_RDATA_I[31:0]};
      default: ext = MEM_RDATA_I;
    endcase
  end

  // trap report helper
  task raise;
    input p;
    input a;
    input il;
    input ac;
    input w;
    begin
      TRAP_O <= 1'b1;
      TRAP_PRIV_O <= p;
      TRAP_ALIGN_O <= a;
      TRAP_ILLEGAL_O <= il;
      TRAP_ACCESS_O <= ac;
      TRAP_WATCH_O <= w;
      DONE_O <= 1'b1;
      MEM_REQ_O <= 1'b0;
      MEM_LOCK_O <= 1'b0;
    end
  endtask

  // sequencer
  always @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      state_q <= `ST_IDLE;
      quad_q <= 1'b0;
      lsub_q <= 1'b0;
      signed_q <= 1'b0;
      size_q <= `SZ_BYTE;
      rd_q <= 5'h00;
      lo_q <= 64'h0000000000000000;
      lane_q <= 3'h0;
      MEM_REQ_O <= 1'b0;
      MEM_WRITE_O <= 1'b0;
      MEM_LOCK_O <= 1'b0;
      MEM_ADDR_O <= 64'h0000000000000000;
      MEM_ASI_O <= 8'h00;
      MEM_SIZE_O <= `SZ_BYTE;
      MEM_LITTLE_O <= 1'b0;
      MEM_BYPASS_O <= 1'b0;
      MEM_NUCLEUS_O <= 1'b0;
      MEM_ATTR_O <= 8'h00;
      MEM_ATTR_FIXED_O <= 1'b0;
      MEM_WATCH_EN_O <= 1'b0;
      MEM_WDATA_O <= 8'h00;
      DONE_O <= 1'b0;
      WB_EN_O <= 1'b0;
      WB_REG_O <= 5'h00;
      WB_DATA_O <= 64'h0000000000000000;
      TRAP_O <= 1'b0;
      TRAP_PRIV_O <= 1'b0;
      TRAP_ALIGN_O <= 1'b0;
      TRAP_ILLEGAL_O <= 1'b0;
      TRAP_ACCESS_O <= 1'b0;
      TRAP_WATCH_O <= 1'b0;
    end else begin
      // completion and trap pulses last one cycle
      DONE_O <= 1'b0;
      WB_EN_O <= 1'b0;
      TRAP_O <= 1'b0;
      TRAP_PRIV_O <= 1'b0;
      TRAP_ALIGN_O <= 1'b0;
      TRAP_ILLEGAL_O <= 1'b0;
      TRAP_ACCESS_O <= 1'b0;
      TRAP_WATCH_O <= 1'b0;
      case (state_q)
        // idle: traps in priority order, else first beat
        `ST_IDLE: begin
          if (ISSUE_I) begin
            if (illegal) begin
              raise(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
            end else if (priv_viol) begin
              raise(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
            end else if (misuse) begin
              raise(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            end else if (misal) begin
              raise(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            end else begin
              // first read, locked only for quad and byte-set, which keep the lock across beats
              state_q <= `ST_READ;
              quad_q <= quad;
              lsub_q <= is_lsub || is_lsuba;
              signed_q <= signed_ld;
              size_q <= size;
              rd_q <= rd_f;
              lane_q <= ea[2:0];
              MEM_REQ_O <= 1'b1;
              MEM_WRITE_O <= 1'b0;
              MEM_LOCK_O <= quad || is_lsub || is_lsuba;
              MEM_ASI_O <= asi;
              MEM_SIZE_O <= size;
              MEM_LITTLE_O <= quad && asi[3];
              MEM_BYPASS_O <= quad && q_phys;
              MEM_NUCLEUS_O <= quad && q_virt;
              MEM_ADDR_O <= (quad && q_phys) ? {21'h000000, ea[`PA_WIDTH-1:0]} : ea;
              MEM_ATTR_O <= (quad && q_phys) ? `ATTR_PHYS : 8'h00;
              MEM_ATTR_FIXED_O <= quad && q_phys;
              MEM_WATCH_EN_O <= 1'b1;
            end
          end
        end

        // first beat answered: late traps, then next step
        `ST_READ: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            if (MEM_FAULT_I || (quad_q && !MEM_CACHEABLE_I)) begin
              raise(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
              state_q <= `ST_IDLE;
            end else if (WATCH_HIT_I) begin
              raise(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
              state_q <= `ST_IDLE;
            end else if (quad_q) begin
              lo_q <= MEM_RDATA_I;
              // second beat at the next doubleword
              MEM_ADDR_O <= MEM_ADDR_O + 64'h0000000000000008;
              MEM_REQ_O <= 1'b1;
              MEM_WATCH_EN_O <= 1'b0;
              state_q <= `ST_QHI;
            end else if (lsub_q) begin
              WB_DATA_O <= ext;
              // lock stays up so nothing slips between read and set
              MEM_WDATA_O <= `ONES_BYTE;
              MEM_WRITE_O <= 1'b1;
              MEM_REQ_O <= 1'b1;
              state_q <= `ST_WRITE;
            end else begin
              WB_DATA_O <= ext;
              WB_REG_O <= rd_q;
              WB_EN_O <= 1'b1;
              DONE_O <= 1'b1;
              state_q <= `ST_IDLE;
            end
          end
        end

        // quad second beat: even half written back now
        `ST_QHI: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_LOCK_O <= 1'b0;
            if (MEM_FAULT_I) begin
              raise(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
              state_q <= `ST_IDLE;
            end else begin
              WB_DATA_O <= lo_q;
              WB_REG_O <= rd_q;
              WB_EN_O <= 1'b1;
              // odd half waits one cycle for its write-back slot
              lo_q <= MEM_RDATA_I;
              state_q <= `ST_DONE;
            end
          end
        end

        // ones-write answered: release lock, report byte
        `ST_WRITE: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WRITE_O <= 1'b0;
            MEM_LOCK_O <= 1'b0;
            WB_REG_O <= rd_q;
            WB_EN_O <= 1'b1;
            DONE_O <= 1'b1;
            state_q <= `ST_IDLE;
          end
        end

        // quad odd half to the odd register
        `ST_DONE: begin
          WB_DATA_O <= lo_q;
          WB_REG_O <= {rd_q[4:1], 1'b1};
          WB_EN_O <= 1'b1;
          DONE_O <= 1'b1;
          state_q <= `ST_IDLE;
        end

        // unused codes fall back to idle
        default: state_q <= `ST_IDLE;
      endcase
    end
  end

endmodule // alt_space_load_atomic_unit

// [alt_load_consts.vh]
// constants for the alternate-space load and atomic unit
`ifndef ALT_LOAD_CONSTS_VH
`define ALT_LOAD_CONSTS_VH
`define F_RD_HI 29
`define F_RD_LO 25
`define F_OP_HI 24
`define F_OP_LO 19
`define F_RS1_HI 18
`define F_RS1_LO 14
`define F_IBIT 13
`define F_ASI_HI 12
`define F_ASI_LO 5
`define F_RS2_HI 4
`define F_RS2_LO 0
`define OP_LDSBA 6'h19
`define OP_LDSHA 6'h1a
`define OP_LDSWA 6'h18
`define OP_LDUBA 6'h11
`define OP_LDUHA 6'h12
`define OP_LDUWA 6'h10
`define OP_LDXA 6'h1b
`define OP_LDDA 6'h13
`define OP_LSUB 6'h0d
`define OP_LSUBA 6'h1d
`define ASI_PRIMARY 8'h80
`define ASI_QV 8'h24
`define ASI_QV_L 8'h2c
`define ASI_QP 8'h34
`define ASI_QP_L 8'h3c
`define ASI_PRIV_BIT 7
`define PA_WIDTH 43
`define QUAD_ALIGN_MASK 64'h000000000000007f
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define SZ_DWORD 2'h3
`define ST_IDLE 3'h0
`define ST_READ 3'h1
`define ST_QHI 3'h2
`define ST_WRITE 3'h3
`define ST_DONE 3'h4
`define ATTR_PHYS 8'h81
`define ONES_BYTE 8'hff
`endif

// [unit_chk.sv]
// assertion checker for the alternate-space load unit
`timescale 1ns/1ps
`include "alt_load_consts.vh"
module unit_chk (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire ISSUE_I,
  input wire [31:0] INSTR_I,
  input wire PRIV_STATE_I,
  input wire BUSY_O,
  input wire MEM_REQ_O,
  input wire MEM_WRITE_O,
  input wire MEM_LOCK_O,
  input wire [63:0] MEM_ADDR_O,
  input wire MEM_BYPASS_O,
  input wire [7:0] MEM_ATTR_O,
  input wire MEM_ATTR_FIXED_O,
  input wire [7:0] MEM_WDATA_O,
  input wire MEM_ACK_I,
  input wire DONE_O,
  input wire WB_EN_O,
  input wire [4:0] WB_REG_O,
  input wire TRAP_PRIV_O,
  input wire TRAP_ILLEGAL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // instruction accepted at this edge
  wire take = ISSUE_I && !BUSY_O;
  wire [5:0] op = INSTR_I[24:19];
  property p_pa; MEM_REQ_O && MEM_BYPASS_O |-> MEM_ADDR_O[63:43] == 21'h0; endproperty
  a_pa: assert property (p_pa) else $error("physical address not truncated");
  property p_attr; MEM_REQ_O && MEM_BYPASS_O |-> MEM_ATTR_FIXED_O && MEM_ATTR_O == `ATTR_PHYS; endproperty
  a_attr: assert property (p_attr) else $error("fixed attributes wrong");
  property p_ones; MEM_REQ_O && MEM_WRITE_O |-> MEM_WDATA_O == `ONES_BYTE; endproperty
  a_ones: assert property (p_ones) else $error("write data not all ones");
  property p_lock; $rose(MEM_WRITE_O) |-> MEM_LOCK_O && $past(MEM_LOCK_O); endproperty
  a_lock: assert property (p_lock) else $error("lock dropped before write");
  property p_priv; take && !PRIV_STATE_I && op == `OP_LDUBA && !INSTR_I[13] && !INSTR_I[12] |=> DONE_O && TRAP_PRIV_O;
  endproperty
  a_priv: assert property (p_priv) else $error("no privileged trap");
  property p_odd; take && op == `OP_LDDA && INSTR_I[25] |=> TRAP_ILLEGAL_O; endproperty
  a_odd: assert property (p_odd) else $error("odd pair not refused");
  property p_one; MEM_ACK_I && MEM_REQ_O && !MEM_LOCK_O |=> DONE_O && !MEM_REQ_O; endproperty
  a_one: assert property (p_one) else $error("plain load not one read");
  property p_pair; WB_EN_O && !DONE_O |-> !WB_REG_O[0] ##1 WB_EN_O && DONE_O && WB_REG_O == ($past(WB_REG_O) | 5'h01);
  endproperty
  a_pair: assert property (p_pair) else $error("quad pair order wrong");
  c_quad: cover property (WB_EN_O && !DONE_O);
  c_set: cover property ($rose(MEM_WRITE_O));
  c_priv: cover property (TRAP_PRIV_O);
endmodule // unit_chk
bind alt_space_load_atomic_unit unit_chk u_chk (.*);

// [mem_model.sv]
// memory side model: random wait, one beat at a time
`timescale 1ns/1ps
module mem_model (
  input wire clk_i,
  input wire rst_n_i,
  input wire req_i,
  input wire write_i,
  input wire [63:0] addr_i,
  output reg ack_o,
  output reg [63:0] rdata_o,
  output reg [63:0] raddr_o,
  output reg [63:0] waddr_o
);
  reg [1:0] wait_q;
  // every byte lane equal, so lane choice cannot matter
  function automatic [63:0] mdata(input [63:0] a);
    mdata = {8{a[7:0] ^ a[15:8] ^ 8'h96}};
  endfunction
  // serve beats strictly in order, data valid only with ack
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (!rst_n_i) begin
      rdata_o <= 64'h0;
      wait_q <= 2'h0;
    end else if (req_i && !ack_o) begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h0) begin
        ack_o <= 1'b1;
        wait_q <= 2'($urandom);
        rdata_o <= mdata(addr_i);
        if (write_i)
          waddr_o <= addr_i;
        else
          raddr_o <= addr_i;
      end
    end
  end
endmodule // mem_model

// [tb_top.sv]
// self-checking bench for the alternate-space load unit
`timescale 1ns/1ps
`include "alt_load_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic CLK_I = 0, RESET_N_I = 0, ISSUE_I = 0, PRIV_STATE_I = 0, MEM_CACHEABLE_I = 1, MEM_FAULT_I = 0, ws = 0;
  logic MEM_ACK_I, WATCH_HIT_I, BUSY_O, MEM_REQ_O, MEM_WRITE_O, MEM_LOCK_O, MEM_LITTLE_O, MEM_BYPASS_O;
  logic MEM_NUCLEUS_O, MEM_ATTR_FIXED_O, MEM_WATCH_EN_O, DONE_O, WB_EN_O, TRAP_O, TRAP_PRIV_O;
  logic TRAP_ALIGN_O, TRAP_ILLEGAL_O, TRAP_ACCESS_O, TRAP_WATCH_O;
  logic [31:0] INSTR_I = 0;
  logic [63:0] SRC1_I = 0, SRC2_I = 0, MEM_ADDR_O, MEM_RDATA_I, WB_DATA_O, raddr, waddr;
  logic [7:0] ASI_REG_I = 0, MEM_ASI_O, MEM_ATTR_O, MEM_WDATA_O;
  logic [1:0] MEM_SIZE_O;
  logic [4:0] WB_REG_O, wr[2];
  logic [63:0] wd[2];
  int mismatches = 0, n_compared = 0, wn;
  logic [5:0] ops[11] = '{`OP_LDSBA, `OP_LDSHA, `OP_LDSWA, `OP_LDUBA, `OP_LDUHA, `OP_LDUWA, `OP_LDXA,
    `OP_LDDA, `OP_LSUB, `OP_LSUBA, 6'h14};
  logic [7:0] asis[6] = '{`ASI_QV, `ASI_QV_L, `ASI_QP, `ASI_QP_L, `ASI_PRIMARY, 8'h04};
  alt_space_load_atomic_unit DUT (.*);
  mem_model P (.clk_i(CLK_I), .rst_n_i(RESET_N_I), .req_i(MEM_REQ_O), .write_i(MEM_WRITE_O),
    .addr_i(MEM_ADDR_O), .ack_o(MEM_ACK_I), .rdata_o(MEM_RDATA_I), .raddr_o(raddr), .waddr_o(waddr));
  // watch hit only on an address with bit 3 set
  assign WATCH_HIT_I = ws & MEM_ADDR_O[3];
  always #2 CLK_I = ~CLK_I;
  // expected register value by size and sign
  function automatic [63:0] ext(input [5:0] op, input [63:0] d);
    case (op)
      `OP_LDSBA: ext = {{56{d[7]}}, d[7:0]};
      `OP_LDSHA: ext = {{48{d[15]}}, d[15:0]};
      `OP_LDSWA: ext = {{32{d[31]}}, d[31:0]};
      `OP_LDUHA: ext = {48'h0, d[15:0]};
      `OP_LDUWA: ext = {32'h0, d[31:0]};
      `OP_LDXA: ext = d;
      default: ext = {56'h0, d[7:0]};
    endcase
  endfunction
  // expected traps {priv, align, illegal, access, watch}
  function automatic [4:0] etrap(input [5:0] op, input rd0, input [63:0] ea, input [7:0] asi, input pv,
    input [2:0] env);
    logic q = asi inside {`ASI_QV, `ASI_QV_L, `ASI_QP, `ASI_QP_L};
    logic [6:0] am = op inside {`OP_LDSHA, `OP_LDUHA} ? 7'h01 : op inside {`OP_LDSWA, `OP_LDUWA} ? 7'h03 :
      op == `OP_LDXA ? 7'h07 : op == `OP_LDDA ? 7'h7f : 7'h00;
    if (op == 6'h14 || (op == `OP_LDDA && (!q || rd0)))
      return 5'h04;
    if (!asi[7] && !pv)
      return 5'h10;
    if (q && op != `OP_LDDA)
      return 5'h02;
    if (|(ea[6:0] & am))
      return 5'h08;
    if (env[2] || (q && env[1]))
      return 5'h02;
    return {4'h0, env[0] & ea[3]};
  endfunction
  // one instruction through issue, memory beats and completion
  task automatic run(input [31:0] ins, input [63:0] a, b, input [7:0] areg, input pv, input [2:0] env);
    logic [5:0] op = ins[24:19];
    logic [63:0] ea = ins[13] ? a + {{51{ins[12]}}, ins[12:0]} : a + b;
    logic [7:0] asi = op == `OP_LSUB ? `ASI_PRIMARY : ins[13] ? areg : ins[12:5];
    logic [4:0] e = etrap(op, ins[25], ea, asi, pv, env);
    logic qd = op == `OP_LDDA;
    logic [1:0] sz = op inside {`OP_LDSHA, `OP_LDUHA} ? `SZ_HALF : op inside {`OP_LDSWA, `OP_LDUWA} ? `SZ_WORD :
      op inside {`OP_LDXA, `OP_LDDA} ? `SZ_DWORD : `SZ_BYTE;
    int n;
    @(posedge CLK_I);
    INSTR_I <= ins;
    SRC1_I <= a;
    SRC2_I <= b;
    ASI_REG_I <= areg;
    PRIV_STATE_I <= pv;
    {MEM_FAULT_I, MEM_CACHEABLE_I, ws} <= env ^ 3'b010;
    ISSUE_I <= 1'b1;
    @(posedge CLK_I);
    ISSUE_I <= 1'b0;
    // look after the issue edge: a trap at issue pulses done only here
    #1;
    `CHK(BUSY_O, MEM_REQ_O)
    if (MEM_REQ_O === 1'b1)
      `CHK({MEM_ASI_O, MEM_SIZE_O, MEM_LITTLE_O, MEM_BYPASS_O, MEM_NUCLEUS_O, MEM_WATCH_EN_O}, {asi, sz, qd & asi[3], qd & asi[4], qd & !asi[4], 1'b1})
    wn = 0;
    for (n = 0; n < 64 && DONE_O !== 1'b1; n++) begin
      @(posedge CLK_I);
      #1;
      if (WB_EN_O === 1'b1 && wn < 2) begin
        wr[wn] = WB_REG_O;
        wd[wn] = WB_DATA_O;
        wn++;
      end
    end
    `CHK({DONE_O, TRAP_O, TRAP_PRIV_O, TRAP_ALIGN_O, TRAP_ILLEGAL_O, TRAP_ACCESS_O, TRAP_WATCH_O}, {2'b11 & {1'b1, |e}, e})
    if (e != 5'h0)
      `CHK(wn, 0)
    else if (op == `OP_LDDA) begin
      `CHK({wn, wr[0], wr[1]}, {32'd2, ins[29:25], ins[29:25] | 5'h01})
      `CHK({wd[0], wd[1]}, {P.mdata(ea), P.mdata(ea + 64'h8)})
      `CHK(raddr, (ea + 64'h8) & (asi[4] ? 64'h000007ffffffffff : ~64'h0))
    end else begin
      `CHK({wn, wr[0], wd[0]}, {32'd1, ins[29:25], ext(op, P.mdata(ea))})
      `CHK(raddr, ea)
      if (op inside {`OP_LSUB, `OP_LSUBA})
        `CHK(waddr, ea)
    end
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence: corners, then random instructions
  initial begin
    logic [31:0] ins;
    logic [63:0] a, b;
    void'($urandom(69480));
    repeat (3) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    run({2'b11, 5'd4, `OP_LDDA, 6'h0, `ASI_QP, 5'h0}, 64'hffff_f000_0000_1000, 64'h80, 8'h0, 1'b0, 3'b000);
    run({2'b11, 5'd5, `OP_LDDA, 6'h0, `ASI_QV, 5'h0}, 64'h1000, 64'h0, 8'h0, 1'b1, 3'b000);
    run({2'b11, 5'd6, `OP_LDDA, 6'h0, `ASI_QV_L, 5'h0}, 64'h1000, 64'h8, 8'h0, 1'b1, 3'b000);
    run({2'b11, 5'd6, `OP_LDDA, 6'h0, `ASI_QP_L, 5'h0}, 64'h2000, 64'h0, 8'h0, 1'b1, 3'b011);
    $display("corner test done");
    for (int t = 0; t < 400; t++) begin
      ins = {2'b11, 30'($urandom)};
      ins[24:19] = ops[$urandom % 11];
      a = {$urandom, $urandom};
      b = {$urandom, $urandom};
      if ($urandom % 2) begin
        a[6:0] = 7'h0;
        b[6:0] = 7'h0;
        ins[6:0] = ins[13] ? 7'h0 : ins[6:0];
      end
      if (!ins[13])
        ins[12:5] = asis[$urandom % 6];
      run(ins, a, b, asis[$urandom % 6], 1'($urandom), {$urandom % 8 == 0, $urandom % 4 == 0, $urandom % 4 == 0});
    end
    $display("random test done");
    conclude;
  end
  // watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    conclude;
  end
endmodule // tb_top
